// >>> logic/rcb_pkg.sv
package rcb_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_TOKEN_IN = 12'h018;
    localparam logic [11:0] OFF_TOKEN_OUT = 12'h01c;
    localparam logic [11:0] OFF_LINK_SRC = 12'h020;
    localparam logic [11:0] OFF_TRIGOUT_SRC = 12'h024;
    localparam logic [11:0] OFF_TRIG_SRC = 12'h040;
    localparam logic [11:0] OFF_CH_MASK = 12'h074;
    localparam logic [11:0] OFF_IRQ_WORD = 12'h084;
    localparam logic [11:0] OFF_IRQ_EVENT = 12'h088;
    localparam logic [11:0] OFF_IRQ_BLOCK = 12'h08c;
    localparam logic [11:0] OFF_HOLD_WORD = 12'h090;
    localparam logic [11:0] OFF_HOLD_EVENT = 12'h094;
    localparam logic [11:0] OFF_HOLD_BLOCK = 12'h098;
    localparam logic [11:0] OFF_SWA_CFG = 12'h108;
    localparam logic [11:0] OFF_SWB_CFG = 12'h10c;
    localparam logic [11:0] OFF_PULSE_PERIOD = 12'h120;
    localparam logic [11:0] OFF_PULSE_LOW = 12'h124;
    localparam logic [11:0] OFF_PULSE_COUNT = 12'h128;
    localparam logic [11:0] OFF_PULSE_START = 12'h12c;
    localparam logic [11:0] OFF_PULSE_STATUS = 12'h130;
    // trigger/sync control bit positions
    localparam int B_L1_TRIG = 0;
    localparam int B_L2_TRIG = 1;
    localparam int B_SL_TRIG = 2;
    localparam int B_SW_TRIG = 3;
    localparam int B_FINE = 4;
    localparam int B_L1_SYNC = 8;
    localparam int B_L2_SYNC = 9;
    localparam int B_SL_SYNC = 10;
    localparam int B_SW_SYNC = 11;
    localparam logic [31:0] TRIG_SRC_RW_MASK = 32'h0000_0717;
    // switch line config fields
    localparam int SEL_W = 5;
    localparam int LINE1_SEL_LSB = 16;
    localparam int LINE0_DIR = 8;
    localparam int LINE1_DIR = 24;
    localparam logic [31:0] SW_CFG_MASK = 32'h011f_011f;
    localparam logic [31:0] SW_CFG_RESET = 32'h0100_0100;
    // selector codes
    localparam logic [4:0] SRC_LOW = 5'h00;
    localparam logic [4:0] SRC_HIGH = 5'h01;
    localparam logic [4:0] SRC_PULSER = 5'h02;
    localparam logic [4:0] SRC_SWA0 = 5'h0a;
    localparam logic [4:0] SRC_SWA1 = 5'h0b;
    localparam logic [4:0] SRC_SWB0 = 5'h0c;
    localparam logic [4:0] SRC_SWB1 = 5'h0d;
    localparam logic [4:0] SRC_BUSY = 5'h0e;
    localparam logic [4:0] SRC_PASS_OUT = 5'h13;
    localparam logic [4:0] SRC_PASS_IN = 5'h14;
    // reset values and the endless pulse count code
    localparam logic [4:0] TOKEN_IN_RESET = 5'h14;
    localparam logic [4:0] TOKEN_OUT_RESET = 5'h13;
    localparam logic [4:0] LINK_SRC_RESET = 5'h00;
    localparam logic [4:0] TRIGOUT_SRC_RESET = 5'h00;
    localparam logic [31:0] PULSE_FOREVER = 32'hffff_ffff;
endpackage

// >>> logic/rcb_config_bank.sv
`timescale 1ns/100ps
// Contract
// [R1] mask bit x set removes channel 64+x from capture and trigger
// [R2] three writable interrupt thresholds: words, events, blocks
// [R3] three writable busy thresholds: words, events, blocks drive busy
// [R4] threshold met when count >= value; interrupt only if enabled
// [R5] common 5-bit selector: 0 low, 1 high, 2 pulser, 10-14, 19, 20
// [R6] three enables admit line1, line2, sync line as trigger sources
// [R7] software trigger bit issues one trigger and self-clears
// [R8] fine capture bit picks 1ns stamping, else clock-synchronous capture
// [R9] three enables admit line1, line2, sync line as sync sources
// [R10] software sync bit issues one sync event and self-clears
// [R11] per switch A line a selector chooses its driving source
// [R12] direction bit zero drives the line, one leaves it undriven
// [R13] switch B lines have identical selectors and direction bits
// [R14] token input selector resets 0x14, token output selector 0x13
// [R15] link and trigger output selectors route chosen source
// [R16] software keeps default direction and selector values
// [R17] pulser period equals programmed count of clock ticks
// [R18] output low for programmed ticks, high for period rest
// [R19] count zero disables, all ones endless, else that many periods
// [R20] any write to start register starts pulser, clears pulse counter
module rcb_config_bank (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    input wire logic [31:0] fifo_word_count_i,
    input wire logic [31:0] fifo_event_count_i,
    input wire logic [31:0] fifo_block_count_i,
    input wire logic irq_enable_i,
    input wire logic readout_pass_out_i,
    input wire logic readout_pass_in_i,
    input wire logic line1_i,
    input wire logic line2_i,
    input wire logic syncline_i,
    input wire logic [1:0] switch_a_line_in_i,
    input wire logic [1:0] switch_b_line_in_i,
    output logic [31:0] channel_disable_o,
    output logic irq_request_o,
    output logic busy_o,
    output logic trigger_o,
    output logic sync_o,
    output logic fine_capture_select_o,
    output logic [1:0] switch_a_line_out_o,
    output logic [1:0] switch_a_line_oe_n_o,
    output logic [1:0] switch_b_line_out_o,
    output logic [1:0] switch_b_line_oe_n_o,
    output logic token_in_o,
    output logic token_out_o,
    output logic link_out_o,
    output logic trigger_out_o,
    output logic pulser_o,
    output logic pulser_done_o
);
    logic [31:0] upper_channel_disable_mask;
    logic [31:0] irq_word_threshold;
    logic [31:0] irq_event_threshold;
    logic [31:0] irq_block_threshold;
    logic [31:0] hold_off_word_threshold;
    logic [31:0] hold_off_event_threshold;
    logic [31:0] hold_off_block_threshold;
    logic [31:0] trigger_sync_source_control;
    logic [31:0] switch_a_line_config;
    logic [31:0] switch_b_line_config;
    logic [4:0] token_input_source_select;
    logic [4:0] token_output_source_select;
    logic [4:0] distribution_link_source_select;
    logic [4:0] trigger_output_source_select;
    logic [31:0] pulser_period_ticks;
    logic [31:0] pulser_low_ticks;
    logic [31:0] pulser_count;
    logic sw_trig_pulse;
    logic sw_sync_pulse;
    logic [31:0] tick;
    logic [31:0] delivered;
    logic running;
    logic [2:0] pins_meta;
    logic [2:0] pins_sync;
    logic [3:0] sw_meta;
    logic [3:0] sw_sync;
    logic [1:0] pass_meta;
    logic [1:0] pass_sync;
    logic [4:0] sel [0:7];
    logic [7:0] routed;
    logic [31:0] src_vec;
    logic next_busy;
    logic next_irq;

    // two-stage synchronisers; first stage read only by second
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_meta <= 3'h0;
            pins_sync <= 3'h0;
            sw_meta <= 4'h0;
            sw_sync <= 4'h0;
            pass_meta <= 2'h0;
            pass_sync <= 2'h0;
        end else begin
            pins_meta <= {syncline_i, line2_i, line1_i};
            pins_sync <= pins_meta;
            sw_meta <= {switch_b_line_in_i, switch_a_line_in_i};
            sw_sync <= sw_meta;
            pass_meta <= {readout_pass_in_i, readout_pass_out_i};
            pass_sync <= pass_meta;
        end
    end

    // configuration register writes
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            upper_channel_disable_mask <= 32'h0;
            irq_word_threshold <= 32'h0;
            irq_event_threshold <= 32'h0;
            irq_block_threshold <= 32'h0;
            hold_off_word_threshold <= 32'h0;
            hold_off_event_threshold <= 32'h0;
            hold_off_block_threshold <= 32'h0;
            trigger_sync_source_control <= 32'h0;
            switch_a_line_config <= rcb_pkg::SW_CFG_RESET;
            switch_b_line_config <= rcb_pkg::SW_CFG_RESET;
            // [R14] selector reset values
            token_input_source_select <= rcb_pkg::TOKEN_IN_RESET;
            token_output_source_select <= rcb_pkg::TOKEN_OUT_RESET;
            distribution_link_source_select <= rcb_pkg::LINK_SRC_RESET;
            trigger_output_source_select <= rcb_pkg::TRIGOUT_SRC_RESET;
            pulser_period_ticks <= 32'h0;
            pulser_low_ticks <= 32'h0;
            pulser_count <= 32'h0;
        end else if (wr_i) begin
            case (addr_i)
                // [R1] disable mask storage
                rcb_pkg::OFF_CH_MASK: upper_channel_disable_mask <= wdata_i;
                // [R2] interrupt thresholds
                rcb_pkg::OFF_IRQ_WORD: irq_word_threshold <= wdata_i;
                rcb_pkg::OFF_IRQ_EVENT: irq_event_threshold <= wdata_i;
                rcb_pkg::OFF_IRQ_BLOCK: irq_block_threshold <= wdata_i;
                // [R3] busy thresholds
                rcb_pkg::OFF_HOLD_WORD: hold_off_word_threshold <= wdata_i;
                rcb_pkg::OFF_HOLD_EVENT: hold_off_event_threshold <= wdata_i;
                rcb_pkg::OFF_HOLD_BLOCK: hold_off_block_threshold <= wdata_i;
                // [R6] [R8] [R9] stored enables; pulse bits kept apart
                rcb_pkg::OFF_TRIG_SRC: begin
                    trigger_sync_source_control <= wdata_i & rcb_pkg::TRIG_SRC_RW_MASK;
                end
                // [R11] [R13] selector and direction fields
                rcb_pkg::OFF_SWA_CFG: switch_a_line_config <= wdata_i & rcb_pkg::SW_CFG_MASK;
                rcb_pkg::OFF_SWB_CFG: switch_b_line_config <= wdata_i & rcb_pkg::SW_CFG_MASK;
                rcb_pkg::OFF_TOKEN_IN: token_input_source_select <= wdata_i[4:0];
                rcb_pkg::OFF_TOKEN_OUT: token_output_source_select <= wdata_i[4:0];
                rcb_pkg::OFF_LINK_SRC: distribution_link_source_select <= wdata_i[4:0];
                rcb_pkg::OFF_TRIGOUT_SRC: trigger_output_source_select <= wdata_i[4:0];
                rcb_pkg::OFF_PULSE_PERIOD: pulser_period_ticks <= wdata_i;
                rcb_pkg::OFF_PULSE_LOW: pulser_low_ticks <= wdata_i;
                rcb_pkg::OFF_PULSE_COUNT: pulser_count <= wdata_i;
                default: ;
            endcase
        end
    end

    // software pulse bits live one cycle, never read back as one
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sw_trig_pulse <= 1'b0;
            sw_sync_pulse <= 1'b0;
        end else begin
            // [R7] self-clearing trigger
            sw_trig_pulse <= wr_i && addr_i == rcb_pkg::OFF_TRIG_SRC
                && wdata_i[rcb_pkg::B_SW_TRIG];
            // [R10] self-clearing sync
            sw_sync_pulse <= wr_i && addr_i == rcb_pkg::OFF_TRIG_SRC
                && wdata_i[rcb_pkg::B_SW_SYNC];
        end
    end

    // pulser: tick counts 0..period-1, low while tick < low ticks
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick <= 32'h0;
            delivered <= 32'h0;
            running <= 1'b0;
        end else if (wr_i && addr_i == rcb_pkg::OFF_PULSE_START) begin
            // [R20] start clears delivered counter; [R19] zero count never runs
            tick <= 32'h0;
            delivered <= 32'h0;
            running <= pulser_count != 32'h0 && pulser_period_ticks != 32'h0;
        end else if (pulser_count == 32'h0 || pulser_period_ticks == 32'h0) begin
            // [R19] zero count disables
            running <= 1'b0;
            tick <= 32'h0;
        end else if (running) begin
            // [R17] period wrap
            if (tick >= pulser_period_ticks - 32'h1) begin
                tick <= 32'h0;
                // [R19] finite count stops, all ones runs forever
                if (pulser_count != rcb_pkg::PULSE_FOREVER) begin
                    delivered <= delivered + 32'h1;
                    if (delivered + 32'h1 >= pulser_count) begin
                        running <= 1'b0;
                    end
                end
            end else begin
                tick <= tick + 32'h1;
            end
        end
    end

    // pulser output and done flag registered
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulser_o <= 1'b0;
            pulser_done_o <= 1'b1;
        end else begin
            // [R18] low phase first, then high
            pulser_o <= running && tick >= pulser_low_ticks;
            pulser_done_o <= !running;
        end
    end

    // [R5] common source vector, reserved codes read low
    always_comb begin
        src_vec = 32'h0;
        src_vec[rcb_pkg::SRC_LOW] = 1'b0;
        src_vec[rcb_pkg::SRC_HIGH] = 1'b1;
        src_vec[rcb_pkg::SRC_PULSER] = pulser_o;
        src_vec[rcb_pkg::SRC_SWA0] = sw_sync[0];
        src_vec[rcb_pkg::SRC_SWA1] = sw_sync[1];
        src_vec[rcb_pkg::SRC_SWB0] = sw_sync[2];
        src_vec[rcb_pkg::SRC_SWB1] = sw_sync[3];
        src_vec[rcb_pkg::SRC_BUSY] = busy_o;
        src_vec[rcb_pkg::SRC_PASS_OUT] = pass_sync[0];
        src_vec[rcb_pkg::SRC_PASS_IN] = pass_sync[1];
    end

    // selector fields for all eight routed outputs
    assign sel[0] = switch_a_line_config[rcb_pkg::SEL_W-1:0];
    assign sel[1] = switch_a_line_config[rcb_pkg::LINE1_SEL_LSB +: rcb_pkg::SEL_W];
    assign sel[2] = switch_b_line_config[rcb_pkg::SEL_W-1:0];
    assign sel[3] = switch_b_line_config[rcb_pkg::LINE1_SEL_LSB +: rcb_pkg::SEL_W];
    assign sel[4] = token_input_source_select;
    assign sel[5] = token_output_source_select;
    assign sel[6] = distribution_link_source_select;
    assign sel[7] = trigger_output_source_select;

    // one registered mux per routed output
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_route
            // [R11] [R13] [R15] selected source routed
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    routed[g] <= 1'b0;
                end else begin
                    routed[g] <= src_vec[sel[g]];
                end
            end
        end
    endgenerate

    assign switch_a_line_out_o = routed[1:0];
    assign switch_b_line_out_o = routed[3:2];
    assign token_in_o = routed[4];
    assign token_out_o = routed[5];
    assign link_out_o = routed[6];
    assign trigger_out_o = routed[7];

    // [R4] greater-or-equal compare, irq gated by enable
    always_comb begin
        next_busy = fifo_word_count_i >= hold_off_word_threshold
            || fifo_event_count_i >= hold_off_event_threshold
            || fifo_block_count_i >= hold_off_block_threshold;
        next_irq = irq_enable_i && (fifo_word_count_i >= irq_word_threshold
            || fifo_event_count_i >= irq_event_threshold
            || fifo_block_count_i >= irq_block_threshold);
    end

    // status, trigger and sync outputs
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o <= 1'b0;
            irq_request_o <= 1'b0;
            trigger_o <= 1'b0;
            sync_o <= 1'b0;
            fine_capture_select_o <= 1'b0;
            channel_disable_o <= 32'h0;
            switch_a_line_oe_n_o <= 2'h3;
            switch_b_line_oe_n_o <= 2'h3;
        end else begin
            // [R3] busy toward trigger distribution
            busy_o <= next_busy;
            // [R2] interrupt request
            irq_request_o <= next_irq;
            // [R6] gated trigger sources
            trigger_o <= (pins_sync[0] && trigger_sync_source_control[rcb_pkg::B_L1_TRIG])
                || (pins_sync[1] && trigger_sync_source_control[rcb_pkg::B_L2_TRIG])
                || (pins_sync[2] && trigger_sync_source_control[rcb_pkg::B_SL_TRIG])
                || sw_trig_pulse;
            // [R9] gated sync sources
            sync_o <= (pins_sync[0] && trigger_sync_source_control[rcb_pkg::B_L1_SYNC])
                || (pins_sync[1] && trigger_sync_source_control[rcb_pkg::B_L2_SYNC])
                || (pins_sync[2] && trigger_sync_source_control[rcb_pkg::B_SL_SYNC])
                || sw_sync_pulse;
            // [R8] capture mode to time-stamp logic
            fine_capture_select_o <= trigger_sync_source_control[rcb_pkg::B_FINE];
            // [R1] mask to channel logic
            channel_disable_o <= upper_channel_disable_mask;
            // [R12] [R13] low enable drives the line
            switch_a_line_oe_n_o <= {switch_a_line_config[rcb_pkg::LINE1_DIR],
                switch_a_line_config[rcb_pkg::LINE0_DIR]};
            switch_b_line_oe_n_o <= {switch_b_line_config[rcb_pkg::LINE1_DIR],
                switch_b_line_config[rcb_pkg::LINE0_DIR]};
        end
    end

    // read port: one cycle after rd_i, unmapped reads zero
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                case (addr_i)
                    rcb_pkg::OFF_CH_MASK: rdata_o <= upper_channel_disable_mask;
                    rcb_pkg::OFF_IRQ_WORD: rdata_o <= irq_word_threshold;
                    rcb_pkg::OFF_IRQ_EVENT: rdata_o <= irq_event_threshold;
                    rcb_pkg::OFF_IRQ_BLOCK: rdata_o <= irq_block_threshold;
                    rcb_pkg::OFF_HOLD_WORD: rdata_o <= hold_off_word_threshold;
                    rcb_pkg::OFF_HOLD_EVENT: rdata_o <= hold_off_event_threshold;
                    rcb_pkg::OFF_HOLD_BLOCK: rdata_o <= hold_off_block_threshold;
                    rcb_pkg::OFF_TRIG_SRC: rdata_o <= trigger_sync_source_control;
                    rcb_pkg::OFF_SWA_CFG: rdata_o <= switch_a_line_config;
                    rcb_pkg::OFF_SWB_CFG: rdata_o <= switch_b_line_config;
                    rcb_pkg::OFF_TOKEN_IN: rdata_o <= {27'h0, token_input_source_select};
                    rcb_pkg::OFF_TOKEN_OUT: rdata_o <= {27'h0, token_output_source_select};
                    rcb_pkg::OFF_LINK_SRC: rdata_o <= {27'h0, distribution_link_source_select};
                    rcb_pkg::OFF_TRIGOUT_SRC: rdata_o <= {27'h0, trigger_output_source_select};
                    rcb_pkg::OFF_PULSE_PERIOD: rdata_o <= pulser_period_ticks;
                    rcb_pkg::OFF_PULSE_LOW: rdata_o <= pulser_low_ticks;
                    rcb_pkg::OFF_PULSE_COUNT: rdata_o <= pulser_count;
                    rcb_pkg::OFF_PULSE_STATUS: rdata_o <= {31'h0, pulser_done_o};
                    default: rdata_o <= 32'h0;
                endcase
            end
        end
    end
endmodule

// >>> verification/rcb_switch_card.sv
`timescale 1ns/100ps
// far side of two single-ended switch lines with weak pull-ups
module rcb_switch_card (
    input wire logic [1:0] dev_out_i,
    input wire logic [1:0] dev_oe_n_i,
    input wire logic [1:0] far_en_i,
    input wire logic [1:0] far_val_i,
    output logic [1:0] line_o
);
    // device drives when enable low, else card or pull-up
    // two drivers at once would be contention, so the card only drives when told to
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            line_o[i] = !dev_oe_n_i[i] ? dev_out_i[i] : (far_en_i[i] ? far_val_i[i] : 1'b1);
        end
    end
endmodule

// >>> verification/rcb_config_bank_asserts.sv
`timescale 1ns/100ps
module rcb_config_bank_asserts (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic irq_enable_i,
    input wire logic [31:0] channel_disable_o,
    input wire logic irq_request_o,
    input wire logic trigger_o,
    input wire logic sync_o,
    input wire logic fine_capture_select_o,
    input wire logic [1:0] switch_a_line_oe_n_o,
    input wire logic link_out_o,
    input wire logic pulser_o,
    input wire logic pulser_done_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // written values reach the outputs two edges later
    property p_mask;
        wr_i && addr_i == rcb_pkg::OFF_CH_MASK |-> ##2 channel_disable_o == $past(wdata_i, 2);
    endproperty
    a_mask: assert property (p_mask) else $error("mask output wrong");
    property p_software_trigger_pulse;
        wr_i && addr_i == rcb_pkg::OFF_TRIG_SRC && wdata_i[3] |-> ##[2:3] trigger_o;
    endproperty
    a_software_trigger_pulse: assert property (p_software_trigger_pulse) else $error("no software trigger");
    property p_software_sync_pulse;
        wr_i && addr_i == rcb_pkg::OFF_TRIG_SRC && wdata_i[11] |-> ##[2:3] sync_o;
    endproperty
    a_software_sync_pulse: assert property (p_software_sync_pulse) else $error("no software sync");
    property p_fine;
        wr_i && addr_i == rcb_pkg::OFF_TRIG_SRC |-> ##2 fine_capture_select_o == $past(wdata_i[4], 2);
    endproperty
    a_fine: assert property (p_fine) else $error("fine capture wrong");
    property p_dir;
        wr_i && addr_i == rcb_pkg::OFF_SWA_CFG
            |-> ##2 switch_a_line_oe_n_o == {$past(wdata_i[24], 2), $past(wdata_i[8], 2)};
    endproperty
    a_dir: assert property (p_dir) else $error("line direction wrong");
    property p_irq;
        irq_request_o |-> $past(irq_enable_i);
    endproperty
    a_irq: assert property (p_irq) else $error("irq while disabled");
    property p_pulse;
        $rose(pulser_o) |-> !pulser_done_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse while stopped");
    property p_link;
        wr_i && addr_i == rcb_pkg::OFF_LINK_SRC && wdata_i[4:1] == 4'h0
            |-> ##2 link_out_o == $past(wdata_i[0], 2);
    endproperty
    a_link: assert property (p_link) else $error("link route wrong");
endmodule

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clock_i, rstn_i, wr_i, rd_i, irq_enable_i, readout_pass_out_i, readout_pass_in_i;
    logic line1_i, line2_i, syncline_i, rvalid_o, irq_request_o, busy_o, trigger_o, sync_o;
    logic fine_capture_select_o, token_in_o, token_out_o, link_out_o, trigger_out_o;
    logic pulser_o, pulser_done_o;
    logic [11:0] addr_i;
    logic [31:0] wdata_i, rdata_o, channel_disable_o;
    logic [31:0] fifo_word_count_i, fifo_event_count_i, fifo_block_count_i;
    logic [1:0] switch_a_line_in_i, switch_b_line_in_i, switch_a_line_out_o, switch_b_line_out_o;
    logic [1:0] switch_a_line_oe_n_o, switch_b_line_oe_n_o, far_en, far_a, far_b;
    int bad_count, num_checks, tr, sy, pu, ru;
    rcb_config_bank rcb_config_bank_i (.*);
    rcb_switch_card rcb_switch_card_i (.dev_out_i(switch_a_line_out_o),
        .dev_oe_n_i(switch_a_line_oe_n_o), .far_en_i(far_en), .far_val_i(far_a),
        .line_o(switch_a_line_in_i));
    rcb_switch_card rcb_switch_card_b_i (.dev_out_i(switch_b_line_out_o),
        .dev_oe_n_i(switch_b_line_oe_n_o), .far_en_i(far_en), .far_val_i(far_b),
        .line_o(switch_b_line_in_i));
    // free running 50 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // one strobe cycle per access, driven at the falling edge
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock_i);
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(negedge clock_i);
        wr_i = 1'b0;
    endtask
    task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        @(negedge clock_i);
        rd_i = 1'b1;
        addr_i = a;
        @(negedge clock_i);
        rd_i = 1'b0;
        chk("rvalid", 1, rvalid_o);
        chk(n, e, rdata_o);
    endtask
    // counts high cycles of the event outputs and rising pulser edges
    task watch(input int n);
        logic last;
        tr = 0; sy = 0; pu = 0; ru = 0;
        last = pulser_o;
        repeat (n) begin
            @(negedge clock_i);
            tr += (trigger_o === 1'b1);
            sy += (sync_o === 1'b1);
            pu += (pulser_o === 1'b1);
            ru += (pulser_o === 1'b1 && last === 1'b0);
            last = pulser_o;
        end
    endtask
    task t_reset;
        rchk("token_in_sel", rcb_pkg::OFF_TOKEN_IN, 32'h14);
        rchk("token_out_sel", rcb_pkg::OFF_TOKEN_OUT, 32'h13);
        rchk("swa_cfg", rcb_pkg::OFF_SWA_CFG, rcb_pkg::SW_CFG_RESET);
        chk("oe_a", 2'b11, switch_a_line_oe_n_o);
        rchk("unmapped", 12'h0fc, 32'h0);
        $display("test reset done");
    endtask
    task t_mask;
        wr(rcb_pkg::OFF_CH_MASK, 32'h8000_0001);
        cyc(2);
        chk("disable", 32'h8000_0001, channel_disable_o);
        rchk("mask", rcb_pkg::OFF_CH_MASK, 32'h8000_0001);
        $display("test mask done");
    endtask
    task t_thresh;
        for (int i = 0; i < 6; i++) wr(12'h084 + 12'(4 * i), (i < 3) ? 32'h3 : 32'h5);
        for (int i = 0; i < 6; i++) rchk("thr", 12'h084 + 12'(4 * i), (i < 3) ? 3 : 5);
        cyc(3);
        chk("busy_low", 0, busy_o);
        fifo_event_count_i = 32'h3;
        cyc(3);
        chk("irq_masked", 0, irq_request_o);
        irq_enable_i = 1'b1;
        cyc(3);
        chk("irq_on", 1, irq_request_o);
        fifo_word_count_i = 32'h5;
        cyc(3);
        chk("busy_on", 1, busy_o);
        $display("test thresholds done");
    endtask
    task t_trig;
        wr(rcb_pkg::OFF_TRIG_SRC, 32'h0000_0818);
        watch(10);
        chk("sw_trig", 1, tr);
        chk("sw_sync", 1, sy);
        rchk("trig_src", rcb_pkg::OFF_TRIG_SRC, 32'h10);
        chk("fine", 1, fine_capture_select_o);
        for (int k = 0; k < 2; k++) begin
            wr(rcb_pkg::OFF_TRIG_SRC, k ? 32'h0000_0202 : 32'h0000_0401);
            line1_i = 1'b1;
            syncline_i = 1'b1;
            watch(8);
            line1_i = 1'b0;
            syncline_i = 1'b0;
            chk("line_trig", !k, tr != 0);
            chk("line_sync", !k, sy != 0);
            cyc(4);
        end
        $display("test trigger done");
    endtask
    task t_mux;
        logic [4:0] cd [9] = '{5'h00, 5'h01, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h13, 5'h14};
        logic ex [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        far_en = 2'b11;
        far_a = 2'b01;
        far_b = 2'b10;
        readout_pass_out_i = 1'b1;
        cyc(4);
        chk("token_in", 0, token_in_o);
        chk("token_out", 1, token_out_o);
        for (int i = 0; i < 9; i++) begin
            wr(rcb_pkg::OFF_TRIGOUT_SRC, {27'h0, cd[i]});
            cyc(3);
            chk("trig_out", ex[i], trigger_out_o);
        end
        wr(rcb_pkg::OFF_LINK_SRC, 32'h1);
        cyc(3);
        chk("link_out", 1, link_out_o);
        $display("test mux done");
    endtask
    task t_sw;
        far_en = 2'b00;
        wr(rcb_pkg::OFF_SWA_CFG, 32'h0100_0001);
        wr(rcb_pkg::OFF_SWB_CFG, 32'h0100_0000);
        cyc(4);
        chk("oe_a", 2'b10, switch_a_line_oe_n_o);
        chk("line_a", 2'b11, switch_a_line_in_i);
        chk("oe_b", 2'b10, switch_b_line_oe_n_o);
        chk("line_b", 2'b10, switch_b_line_in_i);
        wr(rcb_pkg::OFF_SWA_CFG, rcb_pkg::SW_CFG_RESET);
        wr(rcb_pkg::OFF_SWB_CFG, rcb_pkg::SW_CFG_RESET);
        $display("test switch lines done");
    endtask
    task t_pulse;
        wr(rcb_pkg::OFF_PULSE_PERIOD, 32'h5);
        wr(rcb_pkg::OFF_PULSE_LOW, 32'h2);
        wr(rcb_pkg::OFF_PULSE_COUNT, 32'h3);
        wr(rcb_pkg::OFF_PULSE_START, 32'h0);
        watch(40);
        chk("pulse_high", 9, pu);
        chk("pulse_rises", 3, ru);
        chk("done", 1, pulser_done_o);
        rchk("start_rd", rcb_pkg::OFF_PULSE_START, 32'h0);
        wr(rcb_pkg::OFF_PULSE_COUNT, 32'h0);
        wr(rcb_pkg::OFF_PULSE_START, 32'h1);
        watch(20);
        chk("pulse_off", 0, pu);
        $display("test pulser done");
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        rstn_i = 0; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0; irq_enable_i = 0;
        fifo_word_count_i = 0; fifo_event_count_i = 0; fifo_block_count_i = 0;
        readout_pass_out_i = 0; readout_pass_in_i = 0; line1_i = 0; line2_i = 0;
        syncline_i = 0; far_en = 0; far_a = 0; far_b = 0;
        repeat (3) @(negedge clock_i);
        rstn_i = 1'b1;
        t_reset;
        t_mask;
        t_thresh;
        t_trig;
        t_mux;
        t_sw;
        t_pulse;
        end_sim;
    end
    // watchdog: the tests need well under 1000 cycles
    initial begin
        #100us;
        bad_count++;
        end_sim;
    end
endmodule
bind rcb_config_bank rcb_config_bank_asserts rcb_config_bank_asserts_i (.*);
